// ==== dpr_pkg.sv ====
// Package with constants and an enumeration for the dual-port RAM port block.
// Behaviour
// - Both enables active: write if rw low, else read.
// - Output enable high forces data pins undriven.
// - Pipelined: enable change takes effect next cycle.
// - Pipelined read data one cycle after flow-through.
// - Pipelined pin state follows previous cycle controls.
// - Counter clear low resets counter to zero.
// - Strobe low loads external address into counter.
// - Strobe selects external address or counter; count increments.
// - Counter works regardless of chip enables.
// - Counter clear inserts no idle cycle.
// - Enable going inactive floats outputs after edge.
// - Mode select low flow-through, high pipelined.
package dpr_pkg;
  localparam int DPR_ADDR_W = 14;
  localparam int DPR_DATA_W = 9;
  localparam int DPR_DEPTH = 16384;
  localparam logic [DPR_ADDR_W-1:0] DPR_CNT_CLEAR = 14'h0000;
  localparam logic [DPR_ADDR_W-1:0] DPR_CNT_STEP = 14'h0001;
  localparam logic DPR_MODE_FLOW = 1'b0;
  localparam logic DPR_MODE_PIPE = 1'b1;

  typedef enum logic [3:0] {
    DPR_CNT_RESET = 4'b0001,
    DPR_CNT_LOAD = 4'b0010,
    DPR_CNT_HOLD = 4'b0100,
    DPR_CNT_INC = 4'b1000
  } dpr_cnt_op_e;
endpackage : dpr_pkg

// ==== dpr_port.sv ====
// One synchronous port of a dual-port RAM with burst counter and output mode.
`timescale 1ns/1ps

// Two-flop synchroniser for a bundle of level pins.
module dpr_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Raw pins and their synchronised copy.
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  if (WIDTH < 1) begin : g_bad_width
    $error("dpr_sync2: WIDTH must be at least 1");
  end

  // The first stage may go metastable, so only the second stage reads it.
  always_comb begin
    next_stage1 = pin_raw;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign pin_sync = stage2;
endmodule : dpr_sync2

module dpr_port #(
  parameter int ADDR_W = dpr_pkg::DPR_ADDR_W,
  parameter int DATA_W = dpr_pkg::DPR_DATA_W,
  parameter int DEPTH = dpr_pkg::DPR_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Chip enables and cycle control.
  input wire logic chip_sel_low_active,
  input wire logic chip_sel_high_active,
  input wire logic rw,
  input wire logic output_enable_n,
  input wire logic output_mode_select,
  // Burst counter control.
  input wire logic address_strobe_n,
  input wire logic burst_count_enable_n,
  input wire logic burst_counter_clear_n,
  // Address and data pins.
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // Shared array side, toward the other port's logic.
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata
);
  import dpr_pkg::*;

  // Refuse sizes that the counter and the array cannot serve; the clear
  // value is cut from a package constant, so ADDR_W may not exceed it.
  if (ADDR_W < 1 || ADDR_W > DPR_ADDR_W) begin : g_bad_addr_w
    $error("dpr_port: ADDR_W out of range");
  end
  if (DATA_W < 1) begin : g_bad_data_w
    $error("dpr_port: DATA_W must be at least 1");
  end
  if (DEPTH < 2 || DEPTH > (1 << ADDR_W)) begin : g_bad_depth
    $error("dpr_port: DEPTH does not fit ADDR_W");
  end

  localparam logic [ADDR_W-1:0] TOP_ADDR = ADDR_W'(DEPTH - 1);

  // Every pin but the clock and reset crosses in through two flops, so a pin value
  // set up before edge k is acted on at edge k+2.
  localparam int PIN_W = ADDR_W + DATA_W + 8;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s2;
  assign pin_raw = {chip_sel_low_active, chip_sel_high_active, rw,
                    output_enable_n, output_mode_select, address_strobe_n,
                    burst_count_enable_n, burst_counter_clear_n, addr,
                    data_in};
  dpr_sync2 #(.WIDTH(PIN_W)) i_pin_sync (
    .clk(clk),
    .rst(rst),
    .pin_raw(pin_raw),
    .pin_sync(pin_s2)
  );

  logic ce0_n;
  logic ce1;
  logic rw_s;
  logic oe_n_s;
  logic mode_s;
  logic ads_n;
  logic burst_count_enable_n_n;
  logic burst_counter_clear_n_n;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] din_s;
  assign {ce0_n, ce1, rw_s, oe_n_s, mode_s, ads_n, burst_count_enable_n_n, burst_counter_clear_n_n,
          addr_s, din_s} = pin_s2;

  // The array itself, shared by both ports in a real part.
  logic [DATA_W-1:0] mem [DEPTH];

  // Burst counter state.
  logic [ADDR_W-1:0] counter;
  logic [ADDR_W-1:0] next_counter;
  dpr_cnt_op_e cnt_op;
  logic [ADDR_W-1:0] int_addr;

  always_comb begin
    if (!burst_counter_clear_n_n) begin
      cnt_op = DPR_CNT_RESET;
    end else if (!ads_n) begin
      cnt_op = DPR_CNT_LOAD;
    end else if (burst_count_enable_n_n) begin
      cnt_op = DPR_CNT_HOLD;
    end else begin
      cnt_op = DPR_CNT_INC;
    end
    // Access uses the counter value that the same edge produces, so a
    // clear or load takes effect without a dead cycle.
    case (cnt_op)
      DPR_CNT_RESET: next_counter = DPR_CNT_CLEAR[ADDR_W-1:0];
      DPR_CNT_LOAD: next_counter = addr_s;
      DPR_CNT_HOLD: next_counter = counter;
      DPR_CNT_INC: begin
        // Wrap at the top word, not at the width, so a DEPTH below the
        // full address range still loops.
        if (counter == TOP_ADDR) begin
          next_counter = DPR_CNT_CLEAR[ADDR_W-1:0];
        end else begin
          next_counter = counter + DPR_CNT_STEP[ADDR_W-1:0];
        end
      end
      default: next_counter = counter;
    endcase
    int_addr = (!ads_n && burst_counter_clear_n_n) ? addr_s : next_counter;
  end

  // Counter ignores the chip enables entirely.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      counter <= '0;
    end else begin
      counter <= next_counter;
    end
  end

  // Cycle decode. Output enable takes no part here, so a read still
  // updates the stages while the pins are floated.
  logic selected;
  logic do_write;
  logic do_read;
  assign selected = !ce0_n && ce1;
  assign do_write = selected && !rw_s;
  assign do_read = selected && rw_s;

  assign mem_we = do_write;
  assign mem_addr = int_addr;
  assign mem_wdata = din_s;

  // A write lands in the array at this edge; a clash with the other port
  // on the same word leaves that word undefined.
  always_ff @(posedge clk) begin
    if (do_write) begin
      mem[int_addr] <= din_s;
    end
  end

  // Output stages: flow stage holds the word read this cycle, the pipe
  // stage holds it one cycle later.
  logic [DATA_W-1:0] flow_data;
  logic flow_drive;
  logic [DATA_W-1:0] pipe_data;
  logic pipe_drive;
  logic [DATA_W-1:0] next_flow_data;
  logic next_flow_drive;
  logic [DATA_W-1:0] next_pipe_data;
  logic next_pipe_drive;

  always_comb begin
    next_flow_data = do_read ? mem[int_addr] : flow_data;
    next_flow_drive = do_read;
    next_pipe_data = flow_data;
    next_pipe_drive = flow_drive;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flow_data <= '0;
      flow_drive <= 1'b0;
      pipe_data <= '0;
      pipe_drive <= 1'b0;
    end else begin
      flow_data <= next_flow_data;
      flow_drive <= next_flow_drive;
      pipe_data <= next_pipe_data;
      pipe_drive <= next_pipe_drive;
    end
  end

  // Output enable is meant to be asynchronous, so it gates the pins
  // after the stages; it still passes the synchroniser, which costs two
  // cycles of reaction in this model.
  // The mode pin picks the stage; changing it in mid-burst would show one
  // word twice or skip one, so it is meant to be strapped.
  logic pipe_mode;
  assign pipe_mode = (mode_s == DPR_MODE_PIPE);
  assign data_out = pipe_mode ? pipe_data : flow_data;
  assign data_oe = !oe_n_s && (pipe_mode ? pipe_drive : flow_drive);
endmodule : dpr_port

// ==== dpr_port_checker.sv ====
// Checker on the port's pins and its array-side view.
`timescale 1ns/1ps
module dpr_port_checker #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 9
) (
  // Pins, with the array-side mem_addr.
  input wire logic clk, rst, chip_sel_low_active, chip_sel_high_active, rw,
  input wire logic output_enable_n, output_mode_select, address_strobe_n,
  input wire logic burst_count_enable_n, burst_counter_clear_n, data_oe,
  input wire logic [ADDR_W-1:0] addr, mem_addr,
  // Array side, with the data_in pin.
  input wire logic mem_we,
  input wire logic [DATA_W-1:0] data_in, mem_wdata
);
  logic [2:0] up;
  wire logic sel = !chip_sel_low_active && chip_sel_high_active;
  wire logic rd = sel && rw;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Sync flops hold stale pins for a few edges after reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) up <= 3'h0;
    else if (!up[2]) up <= up + 3'h1;
  end
  oe_off_a: assert property ($past(output_enable_n, 2) |-> !data_oe)
    else $error("oe off");
  we_a: assert property (up[2] |-> mem_we == $past(sel && !rw, 2))
    else $error("write");
  wdata_a: assert property (mem_we |-> mem_wdata == $past(data_in, 2))
    else $error("wdata");
  rd_a: assert property (up[2] && !$past(output_enable_n, 2) &&
    ($past(output_mode_select, 2) ? $past(rd, 4) : $past(rd, 3)) |->
    data_oe)
    else $error("read");
  off_a: assert property (up[2] &&
    !($past(output_mode_select, 2) ? $past(rd, 4) : $past(rd, 3)) |->
    !data_oe)
    else $error("float");
  clear_a: assert property (up[2] &&
    !$past(burst_counter_clear_n, 2) |-> mem_addr == '0) else $error("clr");
  load_a: assert property (up[2] && $past(burst_counter_clear_n, 2) &&
    !$past(address_strobe_n, 2) |-> mem_addr == $past(addr, 2))
    else $error("load");
  step_a: assert property (up[2] &&
    $past(burst_counter_clear_n, 2) && $past(address_strobe_n, 2) |->
    mem_addr == $past(mem_addr) + ADDR_W'(!$past(burst_count_enable_n, 2)))
    else $error("step");
endmodule : dpr_port_checker

bind dpr_port dpr_port_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
  .clk, .rst, .chip_sel_low_active, .chip_sel_high_active, .rw, .data_oe,
  .output_enable_n, .output_mode_select, .address_strobe_n, .addr, .mem_we,
  .burst_count_enable_n, .burst_counter_clear_n, .mem_addr, .data_in,
  .mem_wdata);

// ==== dpr_master.sv ====
// Bus master model driving the port's pins.
`timescale 1ns/1ps
module dpr_master
  import dpr_pkg::*;
(
  input wire logic clk,
  output logic chip_sel_low_active, chip_sel_high_active, rw, output_enable_n,
  output logic output_mode_select, address_strobe_n, burst_count_enable_n,
  output logic burst_counter_clear_n,
  output logic [dpr_pkg::DPR_ADDR_W-1:0] addr,
  output logic [dpr_pkg::DPR_DATA_W-1:0] data_in
);
  initial begin
    {chip_sel_low_active, chip_sel_high_active, rw, output_enable_n} = 4'ha;
    {output_mode_select, address_strobe_n} = 2'h1;
    {burst_count_enable_n, burst_counter_clear_n} = 2'h3;
    addr = '0;
    data_in = '0;
  end
  // Both enables move together, so no half-selected cycle occurs.
  task cyc(input logic s, r, o, a, c, k, input logic [DPR_ADDR_W-1:0] x,
    input logic [DPR_DATA_W-1:0] d);
    @(posedge clk);
    chip_sel_low_active <= !s;
    chip_sel_high_active <= s;
    {rw, output_enable_n, address_strobe_n} <= {r, o, a};
    {burst_count_enable_n, burst_counter_clear_n} <= {c, k};
    addr <= x;
    data_in <= d;
  endtask : cyc
  task set_mode(input logic m);
    @(posedge clk);
    output_mode_select <= m;
  endtask : set_mode
endmodule : dpr_master

// ==== tb.sv ====
// Self-checking bench for one port of the dual-port RAM.
`timescale 1ns/1ps
module tb;
  import dpr_pkg::*;
  int n_fail = 0;
  int cmp_count = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic chip_sel_low_active, chip_sel_high_active, rw, output_enable_n;
  logic output_mode_select, address_strobe_n, burst_count_enable_n;
  logic burst_counter_clear_n, data_oe;
  logic [DPR_ADDR_W-1:0] addr;
  logic [DPR_DATA_W-1:0] data_in, data_out;
  dpr_master i_mst (.clk, .chip_sel_low_active, .chip_sel_high_active, .rw,
    .output_enable_n, .output_mode_select, .address_strobe_n, .addr,
    .burst_count_enable_n, .burst_counter_clear_n, .data_in);
  dpr_port i_dut (.clk, .rst, .chip_sel_low_active, .chip_sel_high_active,
    .rw, .output_enable_n, .output_mode_select, .address_strobe_n, .addr,
    .burst_count_enable_n, .burst_counter_clear_n, .data_in, .data_out,
    .data_oe, .mem_we(), .mem_addr(), .mem_wdata());
  initial begin
    forever #50 clk = ~clk;
  end
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // Idles the port so held pins cannot step the counter, then samples.
  task chk(input int l, input logic e, input logic [DPR_DATA_W-1:0] d);
    i_mst.cyc(0, 1, 0, 1, 1, 1, '0, '0);
    repeat (l - 1) @(posedge clk);
    #1;
    cmp_count++;
    if (data_oe !== e || (e && data_out !== d)) begin
      n_fail++;
      $display("CHECK FAILED data pins: expected %b %h seen %b %h", e, d,
        data_oe, data_out);
    end
    $display("test %0d done", cmp_count);
  endtask : chk
  initial begin
    repeat (400) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    i_mst.cyc(1, 0, 0, 0, 1, 1, 14'h3fff, 9'h1a5);
    i_mst.cyc(1, 0, 0, 1, 0, 1, '0, 9'h05a);
    i_mst.cyc(1, 1, 0, 1, 1, 0, '0, '0);
    chk(3, 1, 9'h05a);
    i_mst.cyc(1, 1, 0, 0, 1, 1, 14'h3fff, '0);
    chk(3, 1, 9'h1a5);
    i_mst.cyc(1, 1, 0, 1, 1, 1, '0, '0);
    chk(3, 1, 9'h1a5);
    i_mst.cyc(0, 1, 0, 1, 0, 1, '0, '0);
    chk(3, 0, '0);
    i_mst.cyc(1, 1, 0, 1, 1, 1, '0, '0);
    chk(3, 1, 9'h05a);
    i_mst.cyc(1, 1, 1, 0, 1, 1, 14'h3fff, '0);
    i_mst.cyc(1, 1, 1, 1, 1, 1, '0, '0);
    chk(2, 0, '0);
    repeat (4) @(posedge clk);
    i_mst.set_mode(1);
    repeat (4) @(posedge clk);
    // After the idle stretch the master writes afresh before reading back.
    i_mst.cyc(1, 0, 0, 0, 1, 1, 14'h0010, 9'h0c3);
    i_mst.cyc(1, 1, 0, 0, 1, 1, 14'h0010, '0);
    chk(4, 1, 9'h0c3);
    close_out();
  end
endmodule : tb
